/* core/oab_pkg.sv */
// Package for the overlay alpha-blend control block of the second overlay window.
// Assumes an APB master with 32-bit data and one clock shared by bus and pixel pipe.
package oab_pkg;

    // Printed register index; the byte address is four times the index
    localparam logic [15:0] OAB_BLEND_CTRL_IDX = 16'h0836;
    localparam logic [15:0] OAB_KEY_COLOUR_IDX = 16'h0840;
    localparam logic [17:0] OAB_BLEND_CTRL_ADDR = {OAB_BLEND_CTRL_IDX, 2'b00};
    localparam logic [17:0] OAB_KEY_COLOUR_ADDR = {OAB_KEY_COLOUR_IDX, 2'b00};

    // Field positions of the blend control register
    localparam int OAB_CONST_ALPHA_LSB = 0;
    localparam int OAB_BLEND_EN_BIT = 8;
    localparam int OAB_MODE_LSB = 9;
    localparam int OAB_TRANSP_EN_BIT = 12;
    localparam int OAB_SWAP_BIT = 13;
    localparam int OAB_SHIFT_EN_BIT = 14;

    // Values after reset and writable-bit masks (bits 15 and 11 are reserved)
    localparam logic [15:0] OAB_BLEND_CTRL_RST = 16'h0000;
    localparam logic [15:0] OAB_BLEND_CTRL_MASK = 16'h77FF;
    localparam logic [23:0] OAB_KEY_COLOUR_RST = 24'h00_0000;

    // Expanded alpha of a set one-bit alpha (half blend)
    localparam logic [7:0] OAB_ALPHA_HALF = 8'h80;

    // Blend mode codes
    typedef enum logic [1:0] {
        OAB_MODE_CONST = 2'b00,
        OAB_MODE_MAP = 2'b01,
        OAB_MODE_BOTH = 2'b10,
        OAB_MODE_RSVD = 2'b11
    } oab_mode_t;

    // Overlay pixel alpha formats
    typedef enum logic [1:0] {
        OAB_FMT_NONE = 2'b00,
        OAB_FMT_1555 = 2'b01,
        OAB_FMT_4444 = 2'b10,
        OAB_FMT_8888 = 2'b11
    } oab_fmt_t;

    // APB slave phases, one-hot
    typedef enum logic [2:0] {
        OAB_APB_IDLE = 3'b001,
        OAB_APB_ACCESS = 3'b010,
        OAB_APB_DONE = 3'b100
    } oab_apb_state_t;

endpackage : oab_pkg

/* core/oab_mix.sv */
// One colour channel of the alpha mixer: out = a*fg + (1-a)*bg, alpha in 1/256 steps.
// Assumes both channel values and alpha are stable for the cycle; purely combinational.
`timescale 1ns/1ps
module oab_mix #(
    parameter int CW = 8
) (
    // Channel values
    input wire logic [CW-1:0] fg_in,
    input wire logic [CW-1:0] bg_in,
    // Weight of fg_in, fraction of 256
    input wire logic [7:0] alpha_in,
    // Mixed channel
    output logic [CW-1:0] mix_out
);
    logic [8:0] inv_alpha;
    logic [CW+8:0] sum;

    // Weights always add to 256, so a full-scale input never overflows the channel
    assign inv_alpha = 9'h100 - {1'b0, alpha_in};
    assign sum = ({1'b0, fg_in} * {1'b0, alpha_in}) + (bg_in * inv_alpha);
    assign mix_out = sum[CW+7:8];

endmodule : oab_mix

/* core/oab_top.sv */
// Blend control and pixel mixer of the second overlay window, register over APB.
// Assumes pixel stream and APB on mclk_in; pixel inputs come from same-clock logic.
// Behaviour
// - Blend enable at bit 8, two-bit blend mode at bits 10..9.
// - Shift enable at bit 14 moves the alpha-map value one place right.
// - One-bit alpha of 1:5:5:5 pixels expands to 00h or 80h.
// - With shift on, 80h becomes C0h and 00h stays 00h.
// - Shift ignored for zero alpha-map values and in constant-alpha mode 00b.
// - Swap bit 13 set: main pixel times alpha plus overlay times one minus alpha.
// - Swap bit clear: alpha weights overlay, one minus alpha weights main.
// - Unswapped output is overlay*alpha + main*(1-alpha); in mode 10b alpha = map times constant.
// - Mode 00b constant, 01b alpha map, 10b both combined, 11b reserved.
// - Alpha is a fraction of one; map precision follows the pixel format.
`timescale 1ns/1ps
module oab_top
    import oab_pkg::*;
#(
    parameter int AW = 18,
    parameter int CW = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pixel stream in
    input wire logic pix_valid_in,
    input wire logic [3*CW-1:0] main_window_pixel_in,
    input wire logic [3*CW-1:0] overlay_window_pixel_in,
    input wire logic [7:0] overlay_alpha_raw_in,
    input wire logic [1:0] overlay_alpha_fmt_in,
    input wire logic overlay_active_in,
    // Pixel stream out
    output logic pix_valid_out,
    output logic [3*CW-1:0] pix_out
);

    // Register state
    logic [15:0] blend_ctrl_r;
    logic [15:0] blend_ctrl_nxt;
    logic [3*CW-1:0] key_colour_r;
    logic [3*CW-1:0] key_colour_nxt;

    // Field views of the control register
    logic blend_en;
    logic [1:0] blend_mode;
    logic [7:0] const_alpha;
    logic transp_en;
    logic swap_en;
    logic shift_en;

    // Fields decode straight from the flops, so pixels see a write one cycle after its edge
    assign blend_en = blend_ctrl_r[OAB_BLEND_EN_BIT];
    assign blend_mode = blend_ctrl_r[OAB_MODE_LSB +: 2];
    assign const_alpha = blend_ctrl_r[OAB_CONST_ALPHA_LSB +: 8];
    assign transp_en = blend_ctrl_r[OAB_TRANSP_EN_BIT];
    assign swap_en = blend_ctrl_r[OAB_SWAP_BIT];
    assign shift_en = blend_ctrl_r[OAB_SHIFT_EN_BIT];

    // ---------------- APB slave ----------------
    oab_apb_state_t apb_state_r;
    oab_apb_state_t apb_state_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;

    // Address decode, used for both the read mux and the write strobes
    function automatic logic [1:0] decode_addr(input logic [AW-1:0] addr);
        decode_addr = 2'b00;
        if (addr == AW'(OAB_BLEND_CTRL_ADDR)) begin
            decode_addr = 2'b01;
        end else if (addr == AW'(OAB_KEY_COLOUR_ADDR)) begin
            decode_addr = 2'b10;
        end
    endfunction : decode_addr

    logic [1:0] hit;
    logic setup_phase;
    logic wr_take;
    logic [31:0] strb_mask;
    logic wr_ctrl;
    logic wr_key;

    assign hit = decode_addr(paddr_in);
    assign setup_phase = psel_in && !penable_in;
    // A write lands only on the edge that completes the access phase
    assign wr_take = psel_in && penable_in && pready_r && pwrite_in && !pslverr_r;
    assign strb_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    // Per-register write strobes; an unmapped address never reaches either
    assign wr_ctrl = wr_take && (hit == 2'b01);
    assign wr_key = wr_take && (hit == 2'b10);

    // Read data and error are prepared in setup so they leave a flop in the access phase
    // Outside a setup both fall back to zero, so they stand for the access cycle only
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (setup_phase) begin
            pslverr_nxt = (hit == 2'b00);
            case (hit)
                2'b01: prdata_nxt = {16'h0000, blend_ctrl_r};
                2'b10: prdata_nxt = {{(32-3*CW){1'b0}}, key_colour_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Zero-wait slave: pready rises in the first access cycle
    // A setup seen in DONE re-arms at once, so back-to-back transfers keep zero waits
    always_comb begin
        apb_state_nxt = apb_state_r;
        case (apb_state_r)
            OAB_APB_IDLE: begin
                if (setup_phase) begin
                    apb_state_nxt = OAB_APB_ACCESS;
                end
            end
            OAB_APB_ACCESS: begin
                apb_state_nxt = OAB_APB_DONE;
            end
            OAB_APB_DONE: begin
                apb_state_nxt = setup_phase ? OAB_APB_ACCESS : OAB_APB_IDLE;
            end
            default: apb_state_nxt = OAB_APB_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            apb_state_r <= OAB_APB_IDLE;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            apb_state_r <= apb_state_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= (apb_state_nxt == OAB_APB_ACCESS);
            pslverr_r <= pslverr_nxt;
        end
    end

    // Register writes honour byte strobes; reserved bits stay zero
    // Byte lanes 0 and 1 reach the control register, lanes 0 to 2 the key colour
    always_comb begin
        blend_ctrl_nxt = blend_ctrl_r;
        key_colour_nxt = key_colour_r;
        if (wr_ctrl) begin
            blend_ctrl_nxt = ((blend_ctrl_r & ~strb_mask[15:0]) | (pwdata_in[15:0] & strb_mask[15:0]))
                             & OAB_BLEND_CTRL_MASK;
        end
        if (wr_key) begin
            key_colour_nxt = (key_colour_r & ~strb_mask[3*CW-1:0]) | (pwdata_in[3*CW-1:0] & strb_mask[3*CW-1:0]);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            blend_ctrl_r <= OAB_BLEND_CTRL_RST;
            key_colour_r <= OAB_KEY_COLOUR_RST;
        end else begin
            blend_ctrl_r <= blend_ctrl_nxt;
            key_colour_r <= key_colour_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;

    // ---------------- Alpha derivation ----------------
    logic [7:0] map_alpha;
    logic [7:0] map_shifted;
    logic shift_apply;
    logic [15:0] combined;
    logic [7:0] alpha_sel;
    logic key_hit;

    // Limitation: pixels arrive already unpacked; no colour format conversion is done here
    // Expand the pixel's own alpha to eight bits; precision follows its format
    always_comb begin
        case (overlay_alpha_fmt_in)
            OAB_FMT_1555: map_alpha = overlay_alpha_raw_in[0] ? OAB_ALPHA_HALF : 8'h00;
            OAB_FMT_4444: map_alpha = {overlay_alpha_raw_in[3:0], 4'h0};
            OAB_FMT_8888: map_alpha = overlay_alpha_raw_in;
            default: map_alpha = 8'h00;
        endcase
    end

    // Shift copies the top bit down, so 80h becomes C0h as the 75 percent step
    assign shift_apply = shift_en && (map_alpha != 8'h00) && (blend_mode != OAB_MODE_CONST);
    assign map_shifted = shift_apply ? {map_alpha[7], map_alpha[7:1]} : map_alpha;
    // Mode 10b keeps the top byte of map times constant, truncating toward zero
    assign combined = map_shifted * const_alpha;

    // Mode selects the alpha source; reserved code mixes nothing in
    always_comb begin
        case (blend_mode)
            OAB_MODE_CONST: alpha_sel = const_alpha;
            OAB_MODE_MAP: alpha_sel = map_shifted;
            OAB_MODE_BOTH: alpha_sel = combined[15:8];
            default: alpha_sel = 8'h00;
        endcase
    end

    // Keying compares the whole overlay colour against the programmed key
    // Trade-off: one 24-bit compare and no per-channel mask, so the key must match exactly
    assign key_hit = transp_en && (overlay_window_pixel_in == key_colour_r);

    // ---------------- Pixel pipeline ----------------
    logic s1_valid_r;
    logic [3*CW-1:0] s1_main_r;
    logic [3*CW-1:0] s1_ovl_r;
    logic [7:0] s1_alpha_r;
    logic s1_swap_r;
    logic [1:0] s1_sel_r;
    logic [1:0] s1_sel_nxt;

    // 0: main pixel, 1: overlay pixel as is, 2: blended
    always_comb begin
        if (!overlay_active_in || key_hit) begin
            s1_sel_nxt = 2'd0;
        end else if (!blend_en || blend_mode == OAB_MODE_RSVD) begin
            s1_sel_nxt = 2'd1;
        end else begin
            s1_sel_nxt = 2'd2;
        end
    end

    // Stage one captures the pixels with the alpha and the settings in force
    // Settings are taken per pixel, so a register write reaches the pixel after its edge
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s1_valid_r <= 1'b0;
            s1_main_r <= '0;
            s1_ovl_r <= '0;
            s1_alpha_r <= 8'h00;
            s1_swap_r <= 1'b0;
            s1_sel_r <= 2'd0;
        end else begin
            s1_valid_r <= pix_valid_in;
            s1_main_r <= main_window_pixel_in;
            s1_ovl_r <= overlay_window_pixel_in;
            s1_alpha_r <= alpha_sel;
            s1_swap_r <= swap_en;
            s1_sel_r <= s1_sel_nxt;
        end
    end

    // Swap chooses which pixel alpha weights
    logic [3*CW-1:0] fg;
    logic [3*CW-1:0] bg;
    logic [3*CW-1:0] mixed;
    logic [3*CW-1:0] out_nxt;

    assign fg = s1_swap_r ? s1_main_r : s1_ovl_r;
    assign bg = s1_swap_r ? s1_ovl_r : s1_main_r;

    // One mixer per colour channel
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            oab_mix #(.CW(CW)) u_mix (
                .fg_in(fg[gi*CW +: CW]),
                .bg_in(bg[gi*CW +: CW]),
                .alpha_in(s1_alpha_r),
                .mix_out(mixed[gi*CW +: CW])
            );
        end
    endgenerate

    // Final pick between the main pixel, the raw overlay pixel and the mixed one
    always_comb begin
        case (s1_sel_r)
            2'd0: out_nxt = s1_main_r;
            2'd1: out_nxt = s1_ovl_r;
            default: out_nxt = mixed;
        endcase
    end

    // Stage two registers the result so every output leaves a flop
    // Latency stays two cycles in every mode, so the valid flag needs no other alignment
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pix_valid_out <= 1'b0;
            pix_out <= '0;
        end else begin
            pix_valid_out <= s1_valid_r;
            pix_out <= out_nxt;
        end
    end

endmodule : oab_top

/* testbench/oab_top_properties.sv */
// Port-level assertions for the overlay blend block.
// Assumes one clock, mclk_in, and the synchronous active-high reset rst_in.
`timescale 1ns/1ps
module oab_props
    import oab_pkg::*;
#(
    parameter int AW = 18,
    parameter int CW = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [AW-1:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Pixel stream
    input wire logic pix_valid_in,
    input wire logic [3*CW-1:0] main_window_pixel_in,
    input wire logic overlay_active_in,
    input wire logic pix_valid_out,
    input wire logic [3*CW-1:0] pix_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Only two word addresses answer without an error
    wire logic is_ctrl = paddr_in == AW'(OAB_BLEND_CTRL_ADDR);
    wire logic mapped = is_ctrl || paddr_in == AW'(OAB_KEY_COLOUR_ADDR);

    a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("pready held too long");
    a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("pready outside access");
    a_err_unmapped: assert property (pready_out && !mapped |-> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_no_err_mapped: assert property (pready_out && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_reserved_zero: assert property (pready_out && !pwrite_in && is_ctrl |-> prdata_out[31:15] == '0 && !prdata_out[11])
        else $error("reserved control bits not zero");
    a_valid_delay: assert property (pix_valid_in |-> ##2 pix_valid_out)
        else $error("pixel valid latency wrong");
    a_invalid_delay: assert property (!pix_valid_in |-> ##2 !pix_valid_out)
        else $error("pixel valid without input");
    a_main_passes: assert property (!overlay_active_in |-> ##2 pix_out == $past(main_window_pixel_in, 2))
        else $error("main pixel not passed outside overlay");
    a_err_with_ready: assert property (!pready_out |-> !pslverr_out)
        else $error("error flag outside access");
    a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
        else $error("read data outside access");
endmodule : oab_props

bind oab_top oab_props #(.AW(AW), .CW(CW)) oab_props_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pix_valid_in(pix_valid_in),
    .main_window_pixel_in(main_window_pixel_in), .overlay_active_in(overlay_active_in),
    .pix_valid_out(pix_valid_out), .pix_out(pix_out));

/* testbench/testbench.sv */
// Self-checking bench: APB register access and pixel mixing of the overlay blend block.
// Assumes the package is compiled first; the checker binds itself to the design.
`timescale 1ns/1ps
module testbench
    import oab_pkg::*;
;
    logic mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
    logic pix_valid_in = 0, overlay_active_in = 0, pready_out, pslverr_out, pix_valid_out, v1 = 0, v2 = 0, chk_on = 0;
    logic [17:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rd, seed = 32'h0000_F6ED;
    logic [3:0] pstrb_in = 4'hF;
    logic [23:0] main_window_pixel_in = '0, overlay_window_pixel_in = '0, pix_out, e1 = '0, e2 = '0, key_m = '0;
    logic [7:0] overlay_alpha_raw_in = '0;
    logic [1:0] overlay_alpha_fmt_in = '0;
    logic [15:0] ctrl_m = '0;
    int failures = 0, checked = 0;
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

    oab_top oab_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pix_valid_in(pix_valid_in),
        .main_window_pixel_in(main_window_pixel_in), .overlay_window_pixel_in(overlay_window_pixel_in),
        .overlay_alpha_raw_in(overlay_alpha_raw_in), .overlay_alpha_fmt_in(overlay_alpha_fmt_in),
        .overlay_active_in(overlay_active_in), .pix_valid_out(pix_valid_out), .pix_out(pix_out));

    // Clock of 100 ns period
    always #50 mclk_in = ~mclk_in;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Reference mixer; truncating 1/256 arithmetic as the design chose
    function automatic logic [23:0] exp_pix(input logic [15:0] c, input logic [23:0] k, m, o,
        input logic [7:0] r, input logic [1:0] f, input logic act);
        logic [7:0] mp, a;
        logic [23:0] fg, bg, res;
        mp = f == 2'b00 ? 8'h00 : f == 2'b01 ? (r[0] ? OAB_ALPHA_HALF : 8'h00) : f == 2'b10 ? {r[3:0], 4'h0} : r;
        if (c[14] && mp != 8'h00 && c[10:9] != 2'b00) mp = {mp[7], mp[7:1]};
        a = c[10:9] == 2'b00 ? c[7:0] : c[10:9] == 2'b01 ? mp : 8'((int'(mp) * int'(c[7:0])) >> 8);
        fg = c[13] ? m : o;
        bg = c[13] ? o : m;
        for (int i = 0; i < 3; i++) res[8*i+:8] = 8'((int'(fg[8*i+:8]) * a + int'(bg[8*i+:8]) * (256 - a)) >> 8);
        if (!c[8] || c[10:9] == 2'b11) res = o;
        if (c[12] && o == k) res = m;
        return act ? res : m;
    endfunction : exp_pix

    // Reference pipeline with the fixed two-cycle latency
    always @(posedge mclk_in) begin
        e1 <= exp_pix(ctrl_m, key_m, main_window_pixel_in, overlay_window_pixel_in, overlay_alpha_raw_in,
            overlay_alpha_fmt_in, overlay_active_in);
        v1 <= pix_valid_in;
        e2 <= e1;
        v2 <= v1;
    end
    // Outputs are compared at the falling edge, where they have settled
    always @(negedge mclk_in) if (chk_on) begin
        `CHK("pix_valid", v2, pix_valid_out)
        if (v2) `CHK("pix", e2, pix_out)
    end

    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    // One APB transfer; the model registers follow at the completing edge
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            final_report();
        end
        rd = prdata_out;
        err = pslverr_out;
        if (w && a == OAB_BLEND_CTRL_ADDR)
            ctrl_m <= {s[1] ? d[15:8] : ctrl_m[15:8], s[0] ? d[7:0] : ctrl_m[7:0]} & OAB_BLEND_CTRL_MASK;
        if (w && a == OAB_KEY_COLOUR_ADDR) key_m <= d[23:0];
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic pix(input logic [23:0] m, o, input logic [7:0] r, input logic [1:0] f, input logic a, v);
        @(posedge mclk_in);
        main_window_pixel_in <= m;
        overlay_window_pixel_in <= o;
        overlay_alpha_raw_in <= r;
        overlay_alpha_fmt_in <= f;
        overlay_active_in <= a;
        pix_valid_in <= v;
    endtask : pix

    initial begin
        logic [15:0] c;
        logic [31:0] r, q;
        logic [15:0] cc [4];
        cc = '{16'h4300, 16'h4180, 16'h6300, 16'h0380};
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk_on <= 1'b1;
        apb(1'b0, OAB_BLEND_CTRL_ADDR, 32'h0, 4'hF);
        `CHK("ctrl_rst", 32'h0000_0000, rd)
        apb(1'b0, OAB_KEY_COLOUR_ADDR, 32'h0, 4'hF);
        `CHK("key_rst", 32'h0000_0000, rd)
        $display("test reset done");
        apb(1'b1, OAB_BLEND_CTRL_ADDR, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, OAB_BLEND_CTRL_ADDR, 32'h0, 4'hF);
        `CHK("ctrl_mask", 32'h0000_77FF, rd)
        apb(1'b1, OAB_BLEND_CTRL_ADDR, 32'h0000_0012, 4'h1);
        apb(1'b1, 18'h0_0100, 32'hFFFF_FFFF, 4'hF);
        `CHK("wr_err", 1'b1, err)
        apb(1'b0, OAB_BLEND_CTRL_ADDR, 32'h0, 4'hF);
        `CHK("ctrl_lane", 32'h0000_7712, rd)
        apb(1'b0, 18'h0_0100, 32'h0, 4'hF);
        `CHK("rd_err", 1'b1, err)
        `CHK("rd_zero", 32'h0000_0000, rd)
        $display("test registers done");
        // Every mode with every swap and shift setting, random pixels
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            c = r[15:0];
            c[10:9] = i[1:0];
            c[13] = i[2];
            c[14] = i[3];
            c[8] = (i % 7) != 0;
            apb(1'b1, OAB_BLEND_CTRL_ADDR, {16'h0000, c}, 4'hF);
            apb(1'b0, OAB_BLEND_CTRL_ADDR, 32'h0, 4'hF);
            `CHK("ctrl_rd", {16'h0000, c & OAB_BLEND_CTRL_MASK}, rd)
            repeat (20) begin
                r = rnd();
                q = rnd();
                pix(r[23:0], q[23:0], q[31:24], r[25:24], r[26] | r[27], r[28] | r[29]);
            end
        end
        $display("test random blend done");
        // Half alpha with and without shift, zero alpha, constant mode
        foreach (cc[k]) begin
            apb(1'b1, OAB_BLEND_CTRL_ADDR, {16'h0000, cc[k]}, 4'hF);
            pix(24'h00_0000, 24'hFF_FFFF, 8'h01, 2'b01, 1'b1, 1'b1);
            pix(24'h00_0000, 24'hFF_FFFF, 8'h00, 2'b01, 1'b1, 1'b1);
        end
        // Hand-worked half alpha on white over black: 80h gives 7Fh, shifted C0h gives BFh
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, OAB_BLEND_CTRL_ADDR, t ? 32'h0000_4300 : 32'h0000_0300, 4'hF);
            pix(24'h00_0000, 24'hFF_FFFF, 8'h01, 2'b01, 1'b1, 1'b1);
            repeat (2) @(posedge mclk_in);
            @(negedge mclk_in);
            `CHK("half_alpha", t ? 24'hBF_BFBF : 24'h7F_7F7F, pix_out)
        end
        $display("test alpha corners done");
        apb(1'b1, OAB_KEY_COLOUR_ADDR, 32'hFF12_3456, 4'hF);
        apb(1'b0, OAB_KEY_COLOUR_ADDR, 32'h0, 4'hF);
        `CHK("key_rd", 32'h0012_3456, rd)
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, OAB_BLEND_CTRL_ADDR, t ? 32'h0000_0140 : 32'h0000_1140, 4'hF);
            pix(24'hAB_CDEF, 24'h12_3456, 8'h00, 2'b00, 1'b1, 1'b1);
            pix(24'hAB_CDEF, 24'h12_3457, 8'h00, 2'b00, 1'b1, 1'b1);
        end
        $display("test transparency done");
        repeat (4) @(posedge mclk_in);
        final_report();
    end
endmodule : testbench
